// ### verilog/dac_port_pkg.sv
// constants and types for the quad dac two-wire slave port
package dac_port_pkg;
   // upper six bits of the bus address; the lowest bit comes from the select pin
   localparam logic [5:0] DEV_ADDR_HI = 6'h06;
   localparam int NUM_CH = 4;
   localparam int DEF_CODE_W = 12;
   localparam int WORD_W = 16;
   // bit slot counting within one nine-clock byte
   localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] FIRST_SLOT = 4'h0;
   // data word field positions
   localparam int PD_HI_POS = 15;
   localparam int PD_LO_POS = 14;
   localparam int CLR_POS = 13;
   localparam int OUTPUT_UPDATE_BIT_POS = 12;
   localparam int CODE_MSB = 11;
   // pointer byte: channel selects sit in the low bits, a at bit 0
   localparam int PTR_SEL_MSB = 3;
   // readback when no single channel is selected
   localparam logic [15:0] RB_DEFAULT = 16'h2000;
   localparam logic [3:0] PTR_RESET = 4'h0;
   localparam logic [1:0] PM_NORMAL = 2'h0;
   typedef enum logic [2:0]
   {
      st_idle,
      st_addr,
      st_ptr,
      st_msb,
      st_lsb,
      st_rd,
      st_skip
   } port_state_t;
endpackage

// ### verilog/bit_sync.sv
// two-flop synchroniser for a group of independent pin levels
`timescale 1ns/1ps
module bit_sync
#(
   parameter int W = 1
)
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // bus lines idle high, so both stages reset high to avoid a false start
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// ### verilog/dac_port_top.sv
// two-wire slave port and command decoder of a quad voltage-output dac
`timescale 1ns/1ps
// Behaviour
// R1: answer bus address 000110 plus select pin as lowest bit.
// R2: slave only; the clock line is never driven.
// R3: master opens each transaction with start, then address and direction bit.
// R4: on address match, hold data low during the ninth clock.
// R5: on mismatch, stay idle until next start; no ack, no data.
// R6: nine clocks per byte, msb first; data changes only while clock low.
// R7: a write ends with a stop from the master.
// R8: a read ends with master no-ack then stop.
// R9: write is address, pointer, two data bytes, each acknowledged, then stop.
// R10: pointer write, repeated start, read address, then two data bytes out.
// R11: a bare read address uses the last stored pointer.
// R12: master ack after second byte resends the same two bytes.
// R13: pointer holds one select bit per channel.
// R14: reserved pointer bits written zero; upper bits ignored.
// R15: several selects set write the same word to each channel.
// R16: two data bytes, msb first, form one 16-bit word.
// R17: word is power mode, clear, load, then left-justified code.
// R18: code width is 8, 10 or 12 bits after the control bits.
// R19: clear bit zero zero-fills all input and dac registers.
// R20: load bit zero updates all dac registers; one leaves them.
// R21: pointer resets to zero; unselected readback is zeros with clear set.
// R22: several channels selected on readback returns the default pattern.
// R23: readback uses write layout with unused bits as zero.
// R24: power mode bits: normal, 1k, 100k, three-state.
// R25: a load moves only input registers written since last update.
// R26: after reset all input and dac registers hold zero, normal mode.
// R27: channel a select is pointer bit 0 up to d at bit 3.
// R28: single-channel readback returns stored control bits and code.
// R29: a write acts only after both data bytes are acknowledged.
module dac_port_top
#(
   parameter int CODE_W = dac_port_pkg::DEF_CODE_W
)
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic address_select_pin_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [dac_port_pkg::NUM_CH-1:0][CODE_W-1:0] dac_value_o,
   output logic [dac_port_pkg::NUM_CH-1:0][1:0] power_mode_o
);
   localparam int NCH = dac_port_pkg::NUM_CH;
   generate
      if (CODE_W != 8 && CODE_W != 10 && CODE_W != 12)
      begin : g_bad_width
         $error("code width must be 8, 10 or 12");
      end
   endgenerate

   logic [2:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic asel_s;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   dac_port_pkg::port_state_t state_q;
   logic [3:0] slot_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic rw_q;
   logic send_lo_q;
   logic master_ack_q;
   logic oe_q;
   logic sda_o_q;
   logic [dac_port_pkg::PTR_SEL_MSB:0] ptr_q;
   logic [7:0] hi_q;
   logic [NCH-1:0][CODE_W-1:0] inp_q;
   logic [NCH-1:0][2:0] ctl_q;
   logic [NCH-1:0] fresh_q;
   logic [NCH-1:0][CODE_W-1:0] dac_q;
   logic [NCH-1:0][1:0] pm_q;
   logic [15:0] word_w;
   logic [CODE_W-1:0] code_w;
   logic byte_end;
   logic commit;
   logic addr_match;
   logic one_hot;
   logic [15:0] rb_word;

   // scl, sda and the select strap all come from outside the clock domain
   bit_sync #(.W(3)) u_sync
   (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .async_i({scl_i, sda_i, address_select_pin_i}),
      .sync_o(pins_s)
   );

   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign asel_s = pins_s[0];
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // all bit timing follows the master's clock edges [R2]
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign addr_match = (rx_q[7:1] == {dac_port_pkg::DEV_ADDR_HI, asel_s}); // [R1]
   assign byte_end = scl_fall && (slot_q == dac_port_pkg::ACK_SLOT);
   // the word only acts once the second data byte's ack clock is over [R29]
   assign commit = byte_end && (state_q == dac_port_pkg::st_lsb); // [R9]
   assign word_w = {hi_q, rx_q}; // [R16]
   assign code_w = word_w[dac_port_pkg::CODE_MSB -: CODE_W]; // [R17] [R18]
   assign one_hot = (ptr_q != 4'h0) && ((ptr_q & (ptr_q - 4'h1)) == 4'h0);
   // readback word; unused low code bits stay zero
   always_comb
   begin
      rb_word = dac_port_pkg::RB_DEFAULT; // [R21] [R22]
      for (int c = 0; c < NCH; c++)
      begin
         if (one_hot && ptr_q[c])
         begin
            rb_word = 16'h0000; // [R23]
            rb_word[dac_port_pkg::PD_HI_POS -: 2] = ctl_q[c][2:1]; // [R28]
            rb_word[dac_port_pkg::CLR_POS] = 1'b1;
            rb_word[dac_port_pkg::OUTPUT_UPDATE_BIT_POS] = ctl_q[c][0];
            rb_word[dac_port_pkg::CODE_MSB -: CODE_W] = inp_q[c];
         end
      end
   end
   // byte framing, acknowledge and transmit
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= dac_port_pkg::st_idle;
         slot_q <= dac_port_pkg::FIRST_SLOT;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         send_lo_q <= 1'b0;
         master_ack_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (start_ev)
      begin
         // a repeated start lands here as well; the start's own clock fall then opens the first slot
         state_q <= dac_port_pkg::st_addr;
         slot_q <= dac_port_pkg::FIRST_SLOT - 4'h1;
         oe_q <= 1'b0;
      end
      else if (stop_ev)
      begin
         state_q <= dac_port_pkg::st_idle;
         oe_q <= 1'b0;
      end
      else if (state_q != dac_port_pkg::st_idle && state_q != dac_port_pkg::st_skip)
      begin
         if (scl_rise)
         begin
            // sample only on the rising edge, where data is stable [R6]
            if (slot_q != dac_port_pkg::ACK_SLOT)
               rx_q <= {rx_q[6:0], sda_s};
            else
               master_ack_q <= ~sda_s;
         end
         if (scl_fall)
         begin
            if (slot_q == dac_port_pkg::ACK_SLOT)
            begin
               slot_q <= dac_port_pkg::FIRST_SLOT;
               oe_q <= 1'b0;
               case (state_q)
                  dac_port_pkg::st_addr:
                  begin
                     if (rw_q)
                     begin
                        // a read straight after the address uses the stored pointer [R11] [R10]
                        state_q <= dac_port_pkg::st_rd;
                        tx_q <= rb_word[15:8];
                        oe_q <= ~rb_word[15];
                        send_lo_q <= 1'b1;
                     end
                     else
                        state_q <= dac_port_pkg::st_ptr;
                  end
                  dac_port_pkg::st_ptr:
                     state_q <= dac_port_pkg::st_msb;
                  dac_port_pkg::st_msb:
                     state_q <= dac_port_pkg::st_lsb;
                  dac_port_pkg::st_lsb:
                     state_q <= dac_port_pkg::st_msb;
                  dac_port_pkg::st_rd:
                  begin
                     if (master_ack_q)
                     begin
                        // keep cycling the same two bytes [R12]
                        tx_q <= send_lo_q ? rb_word[7:0] : rb_word[15:8];
                        oe_q <= send_lo_q ? ~rb_word[7] : ~rb_word[15];
                        send_lo_q <= ~send_lo_q;
                     end
                     else
                        state_q <= dac_port_pkg::st_skip;
                  end
                  default:
                     state_q <= dac_port_pkg::st_skip;
               endcase
            end
            else
            begin
               slot_q <= slot_q + 4'h1; // [R6]
               if (slot_q == dac_port_pkg::LAST_DATA_SLOT)
               begin
                  case (state_q)
                     dac_port_pkg::st_addr:
                     begin
                        rw_q <= rx_q[0];
                        if (addr_match)
                           oe_q <= 1'b1; // [R4]
                        else
                           state_q <= dac_port_pkg::st_skip; // [R5]
                     end
                     dac_port_pkg::st_rd:
                        oe_q <= 1'b0;
                     default:
                        oe_q <= 1'b1; // [R9]
                  endcase
               end
               else if (state_q == dac_port_pkg::st_rd)
               begin
                  // msb first; the line is only pulled low, never driven high
                  tx_q <= {tx_q[6:0], 1'b0};
                  oe_q <= ~tx_q[6];
               end
            end
         end
      end
   end
   // open-drain data line: the driven level is always low
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         sda_o_q <= 1'b0;
      else
         sda_o_q <= 1'b0;
   end
   // pointer and upper data byte capture
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ptr_q <= dac_port_pkg::PTR_RESET; // [R21]
         hi_q <= 8'h00;
      end
      else
      begin
         // upper pointer bits are don't-care and dropped [R14] [R27] [R13]
         if (byte_end && state_q == dac_port_pkg::st_ptr)
            ptr_q <= rx_q[dac_port_pkg::PTR_SEL_MSB:0];
         if (byte_end && state_q == dac_port_pkg::st_msb)
            hi_q <= rx_q;
      end
   end
   // input and dac register banks
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         inp_q <= '0; // [R26]
         dac_q <= '0;
         ctl_q <= '0;
         fresh_q <= '0;
         pm_q <= {NCH{dac_port_pkg::PM_NORMAL}};
      end
      else if (commit)
      begin
         if (!word_w[dac_port_pkg::CLR_POS])
         begin
            inp_q <= '0; // [R19]
            dac_q <= '0;
            fresh_q <= '0;
         end
         else
         begin
            for (int c = 0; c < NCH; c++)
            begin
               if (ptr_q[c])
               begin
                  // the same word and control bits go to every selected channel [R15]
                  inp_q[c] <= code_w;
                  ctl_q[c] <= {word_w[dac_port_pkg::PD_HI_POS -: 2], word_w[dac_port_pkg::OUTPUT_UPDATE_BIT_POS]};
                  pm_q[c] <= word_w[dac_port_pkg::PD_HI_POS -: 2]; // [R24]
               end
               if (!word_w[dac_port_pkg::OUTPUT_UPDATE_BIT_POS])
               begin
                  // only registers written since their last update move [R20] [R25]
                  if (ptr_q[c])
                     dac_q[c] <= code_w;
                  else if (fresh_q[c])
                     dac_q[c] <= inp_q[c];
                  fresh_q[c] <= 1'b0;
               end
               else if (ptr_q[c])
                  fresh_q[c] <= 1'b1;
            end
         end
      end
   end
   assign sda_o = sda_o_q;
   assign sda_oe_o = oe_q;
   assign dac_value_o = dac_q;
   assign power_mode_o = pm_q;
   addr_ack_a: assert property ( // [R4]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (state_q == dac_port_pkg::st_addr && scl_fall && slot_q == dac_port_pkg::LAST_DATA_SLOT
       && addr_match && !start_ev && !stop_ev) |=> oe_q ##1 (oe_q throughout (!scl_fall)[*1]))
      else $error("address match not acknowledged");
   no_match_a: assert property ( // [R5]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (state_q == dac_port_pkg::st_skip) |-> !oe_q)
      else $error("data line driven while not addressed");
   sda_change_a: assert property ( // [R6]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $changed(oe_q) |-> $past(scl_fall || start_ev || stop_ev))
      else $error("data line changed while clock high");
   zero_fill_a: assert property ( // [R19]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (commit && !word_w[dac_port_pkg::CLR_POS]) |=> (dac_q == '0 && inp_q == '0))
      else $error("clear did not zero-fill registers");
   hold_dac_a: assert property ( // [R20]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (commit && word_w[dac_port_pkg::CLR_POS] && word_w[dac_port_pkg::OUTPUT_UPDATE_BIT_POS])
      |=> (dac_q == $past(dac_q)))
      else $error("dac registers changed with load bit set");
   multi_rb_a: assert property ( // [R22]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (!one_hot) |-> (rb_word == dac_port_pkg::RB_DEFAULT))
      else $error("readback not default with zero or several selects");
   chan_write_a: assert property ( // [R15]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (commit && word_w[dac_port_pkg::CLR_POS] && ptr_q[0] && ptr_q[3])
      |=> (inp_q[0] == $past(code_w) && inp_q[3] == $past(code_w)))
      else $error("multi-channel write missed a channel");
   power_mode_a: assert property ( // [R24]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (commit && word_w[dac_port_pkg::CLR_POS] && ptr_q[1])
      |=> (pm_q[1] == $past(word_w[dac_port_pkg::PD_HI_POS -: 2])))
      else $error("power mode not taken from written word");
   no_commit_a: assert property ( // [R29]
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (state_q != dac_port_pkg::st_lsb) |=> (inp_q == $past(inp_q) && dac_q == $past(dac_q)))
      else $error("registers changed outside a completed write");
endmodule

// ### dv/bus_master_model.sv
// behavioural two-wire bus master that drives the clock and data lines
`timescale 1ns/1ps
module bus_master_model
(
   input wire logic clk_sys_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_drv_o
);
   // the clock line idles high between frames; only this model ever drives it
   initial
   begin
      scl_o = 1'b1;
      sda_drv_o = 1'b1;
   end

   // each slot ends on a clock fall; data moves 12 ns into the low phase
   task automatic bit_slot(input logic drv, output logic seen);
      #12 sda_drv_o = drv;
      #4 scl_o = 1'b1;
      #8 seen = sda_i;
      #8 scl_o = 1'b0;
   endtask

   // also serves as repeated start after an ack slot
   task automatic start_cond();
      @(negedge clk_sys_i);
      #12 sda_drv_o = 1'b1;
      #8 scl_o = 1'b1;
      #8 sda_drv_o = 1'b0;
      #8 scl_o = 1'b0;
   endtask

   task automatic stop_cond();
      #12 sda_drv_o = 1'b0;
      #8 scl_o = 1'b1;
      #8 sda_drv_o = 1'b1;
      #8;
   endtask

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(b[i], s);
      bit_slot(1'b1, s);
      ack = ~s;
   endtask

   // a released line reads high through the pull-up
   task automatic get_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(1'b1, b[i]);
      bit_slot(~ack, s);
   endtask
endmodule

// ### dv/testbench.sv
// self-checking bench for the quad dac two-wire slave port
`timescale 1ns/1ps
module testbench;
   localparam int CW = 12;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic address_select_pin_i = 1'b0;
   logic scl;
   logic sda_drv;
   logic sda_o;
   logic sda_oe_o;
   logic [3:0][CW-1:0] dac_value_o;
   logic [3:0][1:0] power_mode_o;
   // open drain: the port only ever pulls low
   wire sda = sda_oe_o ? 1'b0 : sda_drv;
   int errors = 0;
   int checked = 0;
   int seed = 32'h7a02;
   int in_code[4], dac_code[4], pmode[4], ldbit[4], pending[4];
   int ptr_m = 0;
   logic ack;
   logic [7:0] rb_hi;
   logic [7:0] rb_lo;
   logic [7:0] ptr;

   always #2 clk_sys_i = ~clk_sys_i;

   dac_port_top #(.CODE_W(CW)) dac_port_top_i
   (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .scl_i(scl),
      .sda_i(sda),
      .address_select_pin_i(address_select_pin_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .dac_value_o(dac_value_o),
      .power_mode_o(power_mode_o)
   );

   bus_master_model bus_master_model_i
   (
      .clk_sys_i(clk_sys_i),
      .sda_i(sda),
      .scl_o(scl),
      .sda_drv_o(sda_drv)
   );

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   function automatic logic [7:0] addr(input logic rw);
      return {dac_port_pkg::DEV_ADDR_HI, address_select_pin_i, rw};
   endfunction

   task automatic compare_all();
      repeat (20) @(negedge clk_sys_i);
      for (int c = 0; c < 4; c++)
      begin
         check("dac value", {4'h0, dac_value_o[c]}, 16'(dac_code[c]));
         check("power mode", {14'h0, power_mode_o[c]}, 16'(pmode[c]));
      end
      check("drive level", {15'h0, sda_o}, 16'h0000);
   endtask

   // clear keeps stored power mode and control bits, per the hand-over
   task automatic model_write(input logic [15:0] w);
      for (int c = 0; c < 4; c++)
         if (!w[13])
         begin
            in_code[c] = 0;
            dac_code[c] = 0;
            pending[c] = 0;
         end
         else if (ptr_m[c])
         begin
            in_code[c] = w[11:0];
            pmode[c] = w[15:14];
            ldbit[c] = w[12];
            pending[c] = 1;
         end
      for (int c = 0; c < 4; c++)
         if (w[13] && !w[12] && pending[c])
         begin
            dac_code[c] = in_code[c];
            pending[c] = 0;
         end
   endtask

   function automatic int model_read();
      int n = 0;
      int s = 0;
      for (int c = 0; c < 4; c++)
         if (ptr_m[c])
         begin
            n++;
            s = c;
         end
      if (n != 1)
         return 32'h2000;
      return (pmode[s] << 14) | 32'h2000 | (ldbit[s] << 12) | in_code[s];
   endfunction

   task automatic send(input logic [7:0] b, input logic exp);
      bus_master_model_i.put_byte(b, ack);
      check("ack", 16'(ack), 16'(exp));
   endtask

   task automatic wr(input logic [7:0] p, input logic [15:0] w);
      bus_master_model_i.start_cond();
      send(addr(1'b0), 1'b1);
      send(p, 1'b1);
      ptr_m = p[3:0];
      send(w[15:8], 1'b1);
      send(w[7:0], 1'b1);
      bus_master_model_i.stop_cond();
      model_write(w);
      compare_all();
   endtask

   task automatic rd(input logic set, input logic [7:0] p, input int reps);
      bus_master_model_i.start_cond();
      if (set)
      begin
         send(addr(1'b0), 1'b1);
         send(p, 1'b1);
         ptr_m = p[3:0];
         bus_master_model_i.start_cond();
      end
      send(addr(1'b1), 1'b1);
      for (int r = 0; r < reps; r++)
      begin
         // the upper byte is always acknowledged; only the last lower byte gets the no-ack
         bus_master_model_i.get_byte(1'b1, rb_hi);
         bus_master_model_i.get_byte(r < reps - 1, rb_lo);
         check("readback", {rb_hi, rb_lo}, 16'(model_read()));
      end
      bus_master_model_i.stop_cond();
   endtask

   initial
   begin
      address_select_pin_i = 1'($random(seed));
      repeat (20) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      compare_all();
      rd(1'b0, 8'h00, 1);
      done("reset");
      wr(8'h01, 16'h7abc);
      rd(1'b1, 8'h01, 1);
      wr(8'h02, 16'h2123);
      done("load");
      for (int p = 0; p < 4; p++)
         wr(8'h04, {2'(p), 2'h2, 12'($random(seed))});
      done("power modes");
      for (int k = 0; k < 6; k++)
      begin
         ptr = {4'h0, 4'($random(seed))};
         wr(ptr, 16'($random(seed)));
         rd(1'b1, ptr, 2);
      end
      rd(1'b0, 8'h00, 1);
      done("random");
      bus_master_model_i.start_cond();
      send({dac_port_pkg::DEV_ADDR_HI, ~address_select_pin_i, 1'b0}, 1'b0);
      send(8'h0f, 1'b0);
      send(8'h00, 1'b0);
      bus_master_model_i.stop_cond();
      compare_all();
      @(negedge clk_sys_i);
      address_select_pin_i = ~address_select_pin_i;
      repeat (8) @(negedge clk_sys_i);
      wr(8'h09, 16'h3fff);
      done("address");
      bus_master_model_i.start_cond();
      send(addr(1'b0), 1'b1);
      send(8'h03, 1'b1);
      send(8'h15, 1'b1);
      bus_master_model_i.stop_cond();
      ptr_m = 3;
      compare_all();
      rd(1'b0, 8'h00, 1);
      wr(8'h01, 16'h0000);
      rd(1'b1, 8'h01, 1);
      done("partial and clear");
      conclude();
   end

   // the whole sequence needs roughly 40 us
   initial
   begin
      #200000;
      errors++;
      $display("watchdog expired");
      conclude();
   end
endmodule
